/* File: plcfg_pkg.sv */
/*
  package for the link and cable-diagnostic configuration register bank:
  register indices, field positions, reset values, masks and timing constants.
  assumes a 16-bit register model placed on a 32-bit avalon-mm word bus.
*/
`default_nettype none
package plcfg_pkg;
  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [9:0] IDX_TEN_MEG_RX = 10'h02a;
  localparam logic [9:0] IDX_LD_SYM = 10'h117;
  localparam logic [9:0] IDX_LD_DESCR = 10'h131;
  localparam logic [9:0] IDX_TDR_CTRL = 10'h170;
  localparam logic [9:0] IDX_TDR_AUX = 10'h171;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h1f0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h1f1;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // ************************************************************
  // reset values and writable masks
  // ************************************************************
  localparam logic [15:0] RST_TEN_MEG_RX = 16'h7998;
  localparam logic [15:0] RST_LD_SYM = 16'h0000;
  localparam logic [15:0] RST_LD_DESCR = 16'h0000;
  localparam logic [15:0] RST_TDR_CTRL = 16'h0c12;
  localparam logic [15:0] RST_TDR_AUX = 16'hc850;
  localparam logic [15:0] WMASK_TEN_MEG_RX = 16'h7fff;
  localparam logic [15:0] WMASK_LD_SYM = 16'hfff0;
  localparam logic [15:0] WMASK_LD_DESCR = 16'hffff;
  localparam logic [15:0] WMASK_TDR_CTRL = 16'h7fff;
  localparam logic [15:0] WMASK_TDR_AUX = 16'hffff;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_SHORT_PREAMBLE = 14;
  localparam int WIN_MSB = 15;
  localparam int WIN_LSB = 10;
  localparam int ERRNUM_MSB = 9;
  localparam int ERRNUM_LSB = 4;
  localparam int DESCR_MSB = 5;
  localparam int DESCR_LSB = 0;
  localparam int BIT_SAME_CHAN = 14;
  localparam int BIT_CHAN_B = 13;
  localparam int BIT_KEEP_OFFSET = 12;
  localparam int AVG_MSB = 10;
  localparam int AVG_LSB = 8;
  localparam int SEG_MSB = 6;
  localparam int SEG_LSB = 4;
  localparam logic [2:0] AVG_RESERVED = 3'h7;
  localparam logic [2:0] SEG_MIN = 3'h1;
  localparam logic [2:0] SEG_MAX = 3'h5;
  // ************************************************************
  // interrupt status bits
  // ************************************************************
  localparam int IRQ_MLT3_DROP = 0;
  localparam int IRQ_DESCR_DROP = 1;
  localparam int IRQ_BAD_CFG = 2;
  localparam int IRQ_W = 3;
  // ************************************************************
  // timing and preamble constants
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WIN_UNIT_NS = 8;
  // one window unit of 8 ns rounds up to whole cycles
  localparam int WIN_UNIT_CYC = (WIN_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LONG_PRE_BYTES = 3'h7;
  localparam logic [2:0] SHORT_PRE_BYTES = 3'h3;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
endpackage
`default_nettype wire

/* File: plcfg_regs.sv */
/*
  link and cable-diagnostic configuration register bank with the logic it steers:
  10 Mbps preamble qualifier, fast link-drop on symbol and descrambler errors,
  and decoded cable-diagnostic set-up for the measurement engine.
  assumes an avalon-mm master with waitrequest, and receive byte and error
  strobes synchronous to sys_clk.
*/
//
// Contract
// - bit 14 of the 10 Mbps receive register resets to one and selects short (1) or long (0) preamble.
// - the preamble mode changes only 10 Mbps reception and leaves 100 Mbps reception untouched.
// - in long mode at least seven preamble bytes are needed and up to seven are consumed before validity.
// - in short mode any preamble longer than three bytes is accepted.
// - fewer preamble bytes may be forwarded to the mac than were received on the line.
// - bits 15-10 set the symbol error window, code n giving n+1 units of 8 ns (the code uses one 10 ns cycle per unit), zero reserved, only in steady link.
// - bits 9-4 set how many symbol errors inside the window drop the link, one to 63, zero reserved.
// - bits 5-0 set the window used to drop the link on descrambler errors.
// - bit 13 picks channel a (0) or b (1) to carry the diagnostic pulse.
// - bit 14 at zero listens on the other channel, at one on the transmit channel.
// - bit 12 keeps the offset-removal filter from being reset before a measurement.
// - bits 10-8 reset to four and average two to the power n cycles, code seven reserved.
// - bits 6-4 reset to one and choose the cable segment one to five, other codes reserved.
`timescale 1ns/1ns
`default_nettype none
module plcfg_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic response1,
  output logic response0,
  input wire logic speed100,
  input wire logic linkSteady,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic mlt3Error,
  input wire logic descrError,
  output logic preambleValid,
  output logic [2:0] preambleFwdCount,
  output logic linkDrop,
  output logic tdrTxChanB,
  output logic tdrRxChanB,
  output logic keepOffsetFilterState,
  output logic [6:0] tdrAvgCycles,
  output logic [2:0] tdrSegment,
  output logic irq
);
  // ************************************************************
  // helper decodes
  // ************************************************************
  // register index from a byte address
  function automatic logic [9:0] regIdx(input logic [11:0] a);
    regIdx = a[plcfg_pkg::ADDR_W-1:plcfg_pkg::IDX_LSB];
  endfunction
  // the two byte-offset bits below the index are ignored: every register is one word
  // byte-lane merge of a 16-bit register under its writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wm;
    merge = (old & ~lane) | (wd[15:0] & lane);
  endfunction

  // ************************************************************
  // register file
  // ************************************************************
  logic [15:0] tenMegRx_r, tenMegRx_nxt;
  logic [15:0] ldSym_r, ldSym_nxt;
  logic [15:0] ldDescr_r, ldDescr_nxt;
  logic [15:0] tdrCtrl_r, tdrCtrl_nxt;
  logic [15:0] tdrAux_r, tdrAux_nxt;
  logic [plcfg_pkg::IRQ_W-1:0] irqStat_r, irqStat_nxt;
  logic [plcfg_pkg::IRQ_W-1:0] irqMask_r, irqMask_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic ack_r, ack_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic [plcfg_pkg::IRQ_W-1:0] irqEvent;
  logic wrHit;
  logic [9:0] idx;

  assign idx = regIdx(address);
  // one wait state: the request is answered on the edge after the ack flop sets
  // a write lands on that answer edge only, while the ack flop is high;
  // read data is captured one edge earlier so that it already stands there
  assign wrHit = write && ack_r;

  // next values of registers and bus answer
  always_comb begin
    logic known;
    known = 1'b1;
    tenMegRx_nxt = tenMegRx_r;
    ldSym_nxt = ldSym_r;
    ldDescr_nxt = ldDescr_r;
    tdrCtrl_nxt = tdrCtrl_r;
    tdrAux_nxt = tdrAux_r;
    irqMask_nxt = irqMask_r;
    irqStat_nxt = irqStat_r;
    readdata_nxt = readdata_r;
    ack_nxt = (read || write) && !ack_r;
    resp_nxt = resp_r;
    unique case (idx)
      plcfg_pkg::IDX_TEN_MEG_RX, plcfg_pkg::IDX_LD_SYM, plcfg_pkg::IDX_LD_DESCR,
      plcfg_pkg::IDX_TDR_CTRL, plcfg_pkg::IDX_TDR_AUX, plcfg_pkg::IDX_IRQ_STAT,
      plcfg_pkg::IDX_IRQ_MASK: known = 1'b1;
      default: known = 1'b0;
    endcase
    if (wrHit) begin
      // masked merges keep read-only bits at zero
      if (idx == plcfg_pkg::IDX_TEN_MEG_RX) tenMegRx_nxt = merge(tenMegRx_r, writedata, byteenable,
                                                                 plcfg_pkg::WMASK_TEN_MEG_RX);
      if (idx == plcfg_pkg::IDX_LD_SYM) ldSym_nxt = merge(ldSym_r, writedata, byteenable,
                                                         plcfg_pkg::WMASK_LD_SYM);
      if (idx == plcfg_pkg::IDX_LD_DESCR) ldDescr_nxt = merge(ldDescr_r, writedata, byteenable,
                                                             plcfg_pkg::WMASK_LD_DESCR);
      if (idx == plcfg_pkg::IDX_TDR_CTRL) tdrCtrl_nxt = merge(tdrCtrl_r, writedata, byteenable,
                                                             plcfg_pkg::WMASK_TDR_CTRL);
      if (idx == plcfg_pkg::IDX_TDR_AUX) tdrAux_nxt = merge(tdrAux_r, writedata, byteenable,
                                                           plcfg_pkg::WMASK_TDR_AUX);
      if (idx == plcfg_pkg::IDX_IRQ_MASK && byteenable[0]) irqMask_nxt = writedata[plcfg_pkg::IRQ_W-1:0];
      if (idx == plcfg_pkg::IDX_IRQ_STAT && byteenable[0])
        irqStat_nxt = irqStat_r & ~writedata[plcfg_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    irqStat_nxt = irqStat_nxt | irqEvent;
    if (read && !ack_r) begin
      unique case (idx)
        plcfg_pkg::IDX_TEN_MEG_RX: readdata_nxt = {16'h0000, tenMegRx_r};
        plcfg_pkg::IDX_LD_SYM: readdata_nxt = {16'h0000, ldSym_r};
        plcfg_pkg::IDX_LD_DESCR: readdata_nxt = {16'h0000, ldDescr_r};
        plcfg_pkg::IDX_TDR_CTRL: readdata_nxt = {16'h0000, tdrCtrl_r};
        plcfg_pkg::IDX_TDR_AUX: readdata_nxt = {16'h0000, tdrAux_r};
        plcfg_pkg::IDX_IRQ_STAT: readdata_nxt = {29'h0000000, irqStat_r};
        plcfg_pkg::IDX_IRQ_MASK: readdata_nxt = {29'h0000000, irqMask_r};
        default: readdata_nxt = 32'h00000000;
      endcase
    end
    if ((read || write) && !ack_r) resp_nxt = known ? 2'h0 : 2'h3; // decodeerror on unmapped
  end

  // register state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tenMegRx_r <= plcfg_pkg::RST_TEN_MEG_RX;
      ldSym_r <= plcfg_pkg::RST_LD_SYM;
      ldDescr_r <= plcfg_pkg::RST_LD_DESCR;
      tdrCtrl_r <= plcfg_pkg::RST_TDR_CTRL;
      tdrAux_r <= plcfg_pkg::RST_TDR_AUX;
      irqStat_r <= '0;
      irqMask_r <= '0;
      readdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      resp_r <= 2'h0;
    end else begin
      tenMegRx_r <= tenMegRx_nxt;
      ldSym_r <= ldSym_nxt;
      ldDescr_r <= ldDescr_nxt;
      tdrCtrl_r <= tdrCtrl_nxt;
      tdrAux_r <= tdrAux_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      readdata_r <= readdata_nxt;
      ack_r <= ack_nxt;
      resp_r <= resp_nxt;
    end
  end

  // bus answer: waitrequest drops once the ack flop is set
  assign waitrequest = (read || write) && !ack_r;
  assign readdata = readdata_r;
  assign response1 = resp_r[1];
  assign response0 = resp_r[0];
  assign irq = |(irqStat_r & irqMask_r);

  // ************************************************************
  // 10 mbps preamble qualifier
  // ************************************************************
  typedef enum logic [1:0] {PQ_IDLE, PQ_COUNT, PQ_BODY} plcfg_pq_e;
  plcfg_pq_e pqState_r, pqState_nxt;
  logic [2:0] preCnt_r, preCnt_nxt;
  logic preValid_r, preValid_nxt;
  logic [2:0] fwd_r, fwd_nxt;
  logic [2:0] needBytes;

  // long mode needs seven bytes, short mode more than three
  assign needBytes = tenMegRx_r[plcfg_pkg::BIT_SHORT_PREAMBLE] ? plcfg_pkg::SHORT_PRE_BYTES + 3'h1
                                                              : plcfg_pkg::LONG_PRE_BYTES;

  // count preamble bytes up to the SFD; a preamble below the need is dropped
  always_comb begin
    pqState_nxt = pqState_r;
    preCnt_nxt = preCnt_r;
    preValid_nxt = 1'b0;
    fwd_nxt = fwd_r;
    if (speed100) begin
      pqState_nxt = PQ_IDLE; // the qualifier is bypassed at 100 Mbps
      preCnt_nxt = 3'h0;
    end else if (!rxByteValid) begin
      pqState_nxt = PQ_IDLE;
      preCnt_nxt = 3'h0;
    end else begin
      unique case (pqState_r)
        PQ_IDLE, PQ_COUNT: begin
          if (rxByte == plcfg_pkg::PREAMBLE_BYTE) begin
            pqState_nxt = PQ_COUNT;
            if (preCnt_r != plcfg_pkg::LONG_PRE_BYTES) preCnt_nxt = preCnt_r + 3'h1;
          end else if (rxByte == plcfg_pkg::SFD_BYTE && preCnt_r >= needBytes) begin
            pqState_nxt = PQ_BODY;
            preValid_nxt = 1'b1;
            fwd_nxt = needBytes; // only the needed bytes go to the mac
          end else begin
            pqState_nxt = PQ_BODY; // frame rejected, wait for end of carrier
            preCnt_nxt = 3'h0;
          end
        end
        // the rest of the frame is ignored until carrier drops
        PQ_BODY: pqState_nxt = PQ_BODY;
      endcase
    end
  end

  // preamble qualifier state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pqState_r <= PQ_IDLE;
      preCnt_r <= 3'h0;
      preValid_r <= 1'b0;
      fwd_r <= 3'h0;
    end else begin
      pqState_r <= pqState_nxt;
      preCnt_r <= preCnt_nxt;
      preValid_r <= preValid_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // at 100 Mbps the preamble is passed straight through
  assign preambleValid = speed100 ? (rxByteValid && rxByte == plcfg_pkg::SFD_BYTE) : preValid_r;
  assign preambleFwdCount = fwd_r;

  // ************************************************************
  // fast link-drop counters
  // ************************************************************
  logic [6:0] winCyc_r, winCyc_nxt;
  logic [5:0] errCnt_r, errCnt_nxt;
  logic [5:0] descrCyc_r, descrCyc_nxt;
  logic descrSeen_r, descrSeen_nxt;
  logic [1:0] unitDiv_r, unitDiv_nxt;
  logic unitTick;
  logic [5:0] winCode, errNum, descrWin;
  logic mlt3Drop, descrDrop, cfgBad;
  logic avgBad, segBad;
  logic [6:0] errNext;

  assign winCode = ldSym_r[plcfg_pkg::WIN_MSB:plcfg_pkg::WIN_LSB];
  assign errNum = ldSym_r[plcfg_pkg::ERRNUM_MSB:plcfg_pkg::ERRNUM_LSB];
  assign descrWin = ldDescr_r[plcfg_pkg::DESCR_MSB:plcfg_pkg::DESCR_LSB];
  assign unitTick = (unitDiv_r == 2'(plcfg_pkg::WIN_UNIT_CYC - 1));
  // error count including the current error, one bit wider so a full count cannot wrap
  assign errNext = {1'b0, errCnt_r} + 7'h01;

  // window of winCode+1 units; errors counted only in steady link
  always_comb begin
    unitDiv_nxt = unitTick ? 2'h0 : unitDiv_r + 2'h1;
    winCyc_nxt = winCyc_r;
    errCnt_nxt = errCnt_r;
    mlt3Drop = 1'b0;
    if (!linkSteady || winCode == 6'h00 || errNum == 6'h00) begin
      winCyc_nxt = 7'h00;
      errCnt_nxt = 6'h00;
    end else begin
      if (mlt3Error && errCnt_r != 6'h3f) errCnt_nxt = errCnt_r + 6'h01;
      if (mlt3Error && errNext >= {1'b0, errNum}) mlt3Drop = 1'b1;
      if (unitTick) begin
        if (winCyc_r >= {1'b0, winCode}) begin
          winCyc_nxt = 7'h00; // window closes, restart the count
          errCnt_nxt = 6'h00;
        end else begin
          winCyc_nxt = winCyc_r + 7'h01;
        end
      end
    end
  end

  // descrambler error window: a second error inside the window drops the link
  always_comb begin
    descrCyc_nxt = descrCyc_r;
    descrSeen_nxt = descrSeen_r;
    descrDrop = 1'b0;
    if (!linkSteady || descrWin == 6'h00) begin
      descrCyc_nxt = 6'h00;
      descrSeen_nxt = 1'b0;
    end else if (descrError) begin
      descrDrop = descrSeen_r;
      descrSeen_nxt = 1'b1;
      descrCyc_nxt = 6'h00;
    end else if (descrSeen_r && unitTick) begin
      if (descrCyc_r >= descrWin) descrSeen_nxt = 1'b0;
      else descrCyc_nxt = descrCyc_r + 6'h01;
    end
  end

  // link-drop state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      unitDiv_r <= 2'h0;
      winCyc_r <= 7'h00;
      errCnt_r <= 6'h00;
      descrCyc_r <= 6'h00;
      descrSeen_r <= 1'b0;
    end else begin
      unitDiv_r <= unitDiv_nxt;
      winCyc_r <= winCyc_nxt;
      errCnt_r <= errCnt_nxt;
      descrCyc_r <= descrCyc_nxt;
      descrSeen_r <= descrSeen_nxt;
    end
  end

  // ************************************************************
  // cable-diagnostic set-up and events
  // ************************************************************
  logic [2:0] avgCode, segCode;
  logic linkDrop_r;
  logic [6:0] avg_r;
  logic [2:0] seg_r;
  logic txB_r, rxB_r, keep_r;

  assign avgCode = tdrCtrl_r[plcfg_pkg::AVG_MSB:plcfg_pkg::AVG_LSB];
  assign segCode = tdrCtrl_r[plcfg_pkg::SEG_MSB:plcfg_pkg::SEG_LSB];
  // each field is judged on its own, so a bad segment leaves the averaging count free
  assign avgBad = avgCode == plcfg_pkg::AVG_RESERVED;
  assign segBad = segCode < plcfg_pkg::SEG_MIN || segCode > plcfg_pkg::SEG_MAX;
  // reserved averaging or segment codes are flagged as an event
  assign cfgBad = avgBad || segBad;
  assign irqEvent = {cfgBad, descrDrop, mlt3Drop};

  // registered set-up outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      linkDrop_r <= 1'b0;
      txB_r <= 1'b0;
      rxB_r <= 1'b0;
      keep_r <= 1'b0;
      avg_r <= 7'h00;
      seg_r <= 3'h0;
    end else begin
      linkDrop_r <= mlt3Drop || descrDrop;
      txB_r <= tdrCtrl_r[plcfg_pkg::BIT_CHAN_B];
      rxB_r <= tdrCtrl_r[plcfg_pkg::BIT_CHAN_B] ^ ~tdrCtrl_r[plcfg_pkg::BIT_SAME_CHAN];
      keep_r <= tdrCtrl_r[plcfg_pkg::BIT_KEEP_OFFSET];
      avg_r <= avgBad ? avg_r : 7'(7'h01 << avgCode);
      seg_r <= segBad ? seg_r : segCode;
    end
  end

  // outputs straight from the set-up flops
  assign linkDrop = linkDrop_r;
  assign tdrTxChanB = txB_r;
  assign tdrRxChanB = rxB_r;
  assign keepOffsetFilterState = keep_r;
  assign tdrAvgCycles = avg_r;
  assign tdrSegment = seg_r;
endmodule // plcfg_regs
`default_nettype wire

/* File: plcfg_regs_monitor.sv */
/*
  checker for the link and cable-diagnostic register bank: bus wait state,
  read-only bits, response codes, tdr decode and the 100 Mbps preamble path.
  assumes it is bound to plcfg_regs and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module plcfg_regs_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic response1,
  input wire logic response0,
  input wire logic speed100,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic preambleValid,
  input wire logic linkDrop,
  input wire logic tdrTxChanB,
  input wire logic tdrRxChanB,
  input wire logic keepOffsetFilterState,
  input wire logic [6:0] tdrAvgCycles
);
  logic [9:0] idx;
  logic rdDone;
  logic wrTdr;
  logic mapped;
  // decode of completed accesses
  assign idx = address[11:2];
  assign rdDone = read && !waitrequest;
  assign wrTdr = write && !waitrequest && idx == plcfg_pkg::IDX_TDR_CTRL && byteenable[1:0] == 2'h3;
  assign mapped = idx inside {10'h02a, 10'h117, 10'h131, 10'h170, 10'h171, 10'h1f0, 10'h1f1};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ************************************************************
  // assertions and covers
  // ************************************************************
  a_wait_one_state: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait state");
  a_ro_bits_zero: assert property (rdDone |-> readdata[31:16] == 16'h0 && !(readdata[15] && (idx == 10'h02a || idx == 10'h170)))
    else $error("read-only bits not zero");
  a_resp_code: assert property (rdDone |-> {response1, response0} == (mapped ? 2'h0 : 2'h3))
    else $error("response code wrong for address");
  a_tx_chan: assert property (wrTdr |-> ##2 tdrTxChanB == $past(writedata[13], 2))
    else $error("transmit channel not taken from write");
  a_rx_cross: assert property (wrTdr |-> ##2 tdrRxChanB == ($past(writedata[14], 2) ~^ $past(writedata[13], 2)))
    else $error("listening channel wrong");
  a_keep_filter: assert property (wrTdr |-> ##2 keepOffsetFilterState == $past(writedata[12], 2))
    else $error("offset filter keep bit wrong");
  a_avg_power: assert property (wrTdr && writedata[10:8] != 3'h7 |-> ##2 tdrAvgCycles == (7'h1 << $past(writedata[10:8], 2)))
    else $error("average count not a power of two of the code");
  a_avg_hold: assert property (wrTdr && writedata[10:8] == 3'h7 |-> ##2 tdrAvgCycles == $past(tdrAvgCycles, 2))
    else $error("reserved average code changed the count");
  a_pre_fast: assert property (speed100 && rxByteValid && rxByte == plcfg_pkg::SFD_BYTE |-> preambleValid)
    else $error("fast path frame start not flagged");
  c_reserved_avg: cover property (wrTdr && writedata[10:8] == 3'h7);
  c_unmapped: cover property (rdDone && !mapped);
  c_link_drop: cover property (linkDrop);
endmodule // plcfg_regs_monitor
bind plcfg_regs plcfg_regs_monitor u_monitor (.*);
`default_nettype wire

/* File: plcfg_regs_tb_top.sv */
/*
  testbench for the link and cable-diagnostic register bank.
  assumes plcfg_sw_model drives the avalon port and the checker is bound.
*/
`timescale 1ns/1ns
`default_nettype none
module plcfg_regs_tb_top;
  logic sys_clk, rst_b, read, write, waitrequest, response1, response0, irq;
  logic speed100, linkSteady, rxByteValid, mlt3Error, descrError, timedOut;
  logic preambleValid, linkDrop, tdrTxChanB, tdrRxChanB, keepOffsetFilterState;
  logic [11:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [7:0] rxByte;
  logic [2:0] preambleFwdCount, tdrSegment, segE;
  logic [6:0] tdrAvgCycles, avgE;
  logic [15:0] w;
  logic [17:0] expQ[$];
  int fails, nTests, pv, drops;
  localparam logic [11:0] AD[7] = '{12'h0a8, 12'h45c, 12'h4c4, 12'h5c0, 12'h5c4, 12'h7c0, 12'h7c4};
  localparam logic [15:0] RV[5] = '{16'h7998, 16'h0000, 16'h0000, 16'h0c12, 16'hc850};
  localparam logic [15:0] WM[5] = '{16'h7fff, 16'hfff0, 16'hffff, 16'h7fff, 16'hffff};
  // speed, short mode, preamble bytes, valid; short mode for short-preamble partners
  localparam logic [5:0] CS[6] = '{6'h19, 6'h16, 6'h0f, 6'h0c, 6'h25, 6'h35};
  plcfg_regs dut (.*);
  plcfg_sw_model m (.*);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [17:0] got, input logic [17:0] want);
    nTests++;
    if (got !== want) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [17:0] e);
    expQ.push_back(e);
    m.xfer(1'h0, a, 16'h0);
  endtask
  task automatic pulse(input logic descr);
    @(posedge sys_clk);
    mlt3Error <= !descr;
    descrError <= descr;
    @(posedge sys_clk);
    mlt3Error <= 1'h0;
    descrError <= 1'h0;
  endtask
  task automatic frame(input logic [2:0] np);
    for (int i = 0; i <= np; i++) begin
      @(posedge sys_clk);
      rxByteValid <= 1'h1;
      rxByte <= (i == np) ? 8'hd5 : 8'h55;
    end
    @(posedge sys_clk);
    rxByteValid <= 1'h0;
    rxByte <= $urandom;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // oldest note against each completed read, plus pulse counters
  always @(posedge sys_clk) begin
    if (read === 1'h1 && waitrequest === 1'h0) begin
      if (expQ.size() == 0) check("unexpected read", 18'h0, 18'h3ffff);
      else check("readback", {response1, response0, readdata[15:0]}, expQ.pop_front());
    end
    if (preambleValid === 1'h1) pv++;
    if (linkDrop === 1'h1) drops++;
  end
  // watchdog on hung accesses and on the whole run
  initial begin
    for (int i = 0; i < 50000 && timedOut !== 1'h1; i++) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst_b = 1'h0;
    speed100 = 1'h0;
    linkSteady = 1'h0;
    rxByteValid = 1'h0;
    rxByte = 8'h0;
    mlt3Error = 1'h0;
    descrError = 1'h0;
    void'($urandom(69));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    for (int k = 0; k < 7; k++) rd(AD[k], {2'h0, k < 5 ? RV[k] : 16'h0});
    rd(12'h100, 18'h30000);
    check("avg reset", tdrAvgCycles, 7'h10);
    check("seg reset", tdrSegment, 3'h1);
    $display("test reset done");
    avgE = 7'h10;
    segE = 3'h1;
    for (int n = 0; n < 8; n++) begin
      w = {1'h0, n[0], n[1], n[2], 1'h1, n[2:0], 1'h0, n[2:0], 4'h2};
      m.xfer(1'h1, AD[3], w);
      if (n < 7) avgE = 7'h1 << n;
      if (n > 0 && n < 6) segE = n[2:0];
      repeat (3) @(posedge sys_clk);
      check("tx chan", tdrTxChanB, n[1]);
      check("rx chan", tdrRxChanB, n[0] ? n[1] : !n[1]);
      check("keep filter", keepOffsetFilterState, n[2]);
      check("avg", tdrAvgCycles, avgE);
      check("seg", tdrSegment, segE);
      rd(AD[3], {2'h0, w});
    end
    $display("test tdr done");
    check("irq masked", irq, 1'h0);
    rd(AD[5], 18'h00004);
    m.xfer(1'h1, AD[6], 16'h0007);
    repeat (2) @(posedge sys_clk);
    check("irq on", irq, 1'h1);
    m.xfer(1'h1, AD[3], RV[3]);
    m.xfer(1'h1, AD[5], 16'h0004);
    repeat (2) @(posedge sys_clk);
    check("irq off", irq, 1'h0);
    rd(AD[5], 18'h0);
    $display("test irq done");
    for (int k = 0; k < 5; k++) begin
      w = $urandom;
      m.xfer(1'h1, AD[k], w);
      rd(AD[k], {2'h0, w & WM[k]});
    end
    m.xfer(1'h1, AD[3], RV[3]);
    m.xfer(1'h1, AD[5], 16'h0007);
    $display("test random done");
    m.xfer(1'h1, AD[1], 16'hfc20);
    m.xfer(1'h1, AD[2], 16'h0005);
    drops = 0;
    pulse(1'h0);
    pulse(1'h0);
    linkSteady <= 1'h1;
    pulse(1'h0);
    repeat (80) @(posedge sys_clk);
    pulse(1'h0);
    repeat (5) @(posedge sys_clk);
    check("no symbol drop", drops, 18'h0);
    pulse(1'h0);
    pulse(1'h0);
    repeat (5) @(posedge sys_clk);
    check("symbol drop", drops > 0, 1'h1);
    drops = 0;
    pulse(1'h1);
    repeat (20) @(posedge sys_clk);
    pulse(1'h1);
    repeat (8) @(posedge sys_clk);
    check("no descr drop", drops, 18'h0);
    pulse(1'h1);
    pulse(1'h1);
    repeat (5) @(posedge sys_clk);
    check("descr drop", drops > 0, 1'h1);
    rd(AD[5], 18'h00003);
    linkSteady <= 1'h0;
    $display("test link drop done");
    for (int c = 0; c < 6; c++) begin
      speed100 <= CS[c][5];
      m.xfer(1'h1, AD[0], {1'h0, CS[c][4], 14'h3998});
      pv = 0;
      frame(CS[c][3:1]);
      check("preamble valid", pv, CS[c][0]);
      if (!CS[c][5] && CS[c][0]) check("forwarded", preambleFwdCount, CS[c][4] ? 3'h4 : 3'h7);
    end
    $display("test preamble done");
    report_and_stop();
  end
endmodule // plcfg_regs_tb_top
`default_nettype wire

/* File: plcfg_sw_model.sv */
/*
  management software model: avalon-mm master issuing one access at a time.
  assumes the bank answers with waitrequest on the shared sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module plcfg_sw_model (
  input wire logic sys_clk,
  input wire logic waitrequest,
  output var logic [11:0] address,
  output var logic read,
  output var logic write,
  output var logic [31:0] writedata,
  output var logic [3:0] byteenable,
  output var logic timedOut
);
  // idle bus at time zero
  initial begin
    address = 12'h0;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    byteenable = 4'h3;
    timedOut = 1'h0;
  end
  // one access: request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int i;
    @(posedge sys_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {16'h0, d};
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (waitrequest === 1'h0) break;
    end
    if (i == 50) timedOut <= 1'h1;
    read <= 1'h0;
    write <= 1'h0;
    writedata <= ~writedata; // released data no longer shows the last value
  endtask
endmodule // plcfg_sw_model
`default_nettype wire
